// ===== common/hbfp_map.vh
// register map, field positions, reset values and timing counts of the bridge protection block
// Contract
// - high-side short to ground and low-side short to supply are overcurrent events.
// - overcurrent first seen on a switch starts its filter timer, no instant shutdown.
// - filter expiry with fault present latches switch off and sets its overcurrent flag.
// - any per-switch overcurrent or open-load flag also sets load error summary, bit 6.
// - overcurrent flag set keeps switch off; enable bits stay at one.
// - temperature warning latches pre-warn flag bit 1; outputs unchanged.
// - thermal shutdown latches bit 2, all outputs off until host clears flag.
// - undervoltage latches bit 5, outputs off, auto restart when supply recovers.
// - overvoltage latches bit 4, outputs off, auto restart when supply recovers.
// - high and low side of one bridge are never on together.
// - dead time inserted between one transistor off and the other on.
// - open load on active switch latches its flag and load error; output stays.
// - any latched fault flag drives fault_indicator_n low.
`ifndef HBFP_MAP_VH
`define HBFP_MAP_VH

// ---------------------------------------------------------------
// register offsets (word index, byte address bits 7:2)
// ---------------------------------------------------------------
`define HBFP_A_GSTAT 6'h00
`define HBFP_A_OC 6'h01
`define HBFP_A_OL 6'h02
`define HBFP_A_ACT 6'h03
`define HBFP_A_LIVE 6'h04
`define HBFP_A_MASK 6'h05

// ---------------------------------------------------------------
// global status field positions
// ---------------------------------------------------------------
`define HBFP_B_PREWARN 1
`define HBFP_B_TSD 2
`define HBFP_B_OV 4
`define HBFP_B_UV 5
`define HBFP_B_LE 6
`define HBFP_GSTAT_MASK 7'h76

// ---------------------------------------------------------------
// reset values
// ---------------------------------------------------------------
`define HBFP_RST_GSTAT 7'h00
`define HBFP_RST_FLAGS 16'h0000
`define HBFP_RST_ACT 16'h0000
`define HBFP_RST_MASK 7'h00

// ---------------------------------------------------------------
// timing
// ---------------------------------------------------------------
`define HBFP_CLK_NS 25
`define HBFP_DT_HL_NS 1000
`define HBFP_DT_LH_NS 1000
`define HBFP_DT_HL_CYC ((`HBFP_DT_HL_NS + `HBFP_CLK_NS - 1) / `HBFP_CLK_NS)
`define HBFP_DT_LH_CYC ((`HBFP_DT_LH_NS + `HBFP_CLK_NS - 1) / `HBFP_CLK_NS)
`define HBFP_OC_FILT_CYC 12'd400

`endif

// ===== hdl/hbfp_bridge.v
// one half-bridge: overcurrent filters, cross-conduction lock and dead time
`timescale 1ns/10ps
`include "hbfp_map.vh"

module hbfp_bridge #(
  parameter [11:0] FILT_CYC = `HBFP_OC_FILT_CYC
) (
  // clock and reset
  input wire hclk,
  input wire hresetn,
  // control
  input wire hs_en,
  input wire ls_en,
  input wire hs_block,
  input wire ls_block,
  // current comparators
  input wire hs_oc_det,
  input wire ls_oc_det,
  // gate drive and trip events
  output reg hs_on_q,
  output reg ls_on_q,
  output reg hs_trip_q,
  output reg ls_trip_q
);

  localparam integer DT_HL_I = `HBFP_DT_HL_CYC;
  localparam integer DT_LH_I = `HBFP_DT_LH_CYC;
  localparam [7:0] DT_HL = DT_HL_I[7:0];
  localparam [7:0] DT_LH = DT_LH_I[7:0];

  reg [11:0] hs_cnt_q;
  reg [11:0] ls_cnt_q;
  reg [7:0] dt_q;
  wire want_hs;
  wire want_ls;
  wire hs_act;
  wire ls_act;
  wire hs_trip;
  wire ls_trip;

  // ---------------------------------------------------------------
  // overcurrent filter
  // ---------------------------------------------------------------
  function [11:0] filt_next;
    input [11:0] c;
    input act;
    begin
      if (!act || c == FILT_CYC - 12'h001) begin
        filt_next = 12'h000;
      end else begin
        filt_next = c + 12'h001;
      end
    end
  endfunction

  assign hs_act = hs_on_q & hs_oc_det;
  assign ls_act = ls_on_q & ls_oc_det;
  assign hs_trip = hs_act && (hs_cnt_q == FILT_CYC - 12'h001);
  assign ls_trip = ls_act && (ls_cnt_q == FILT_CYC - 12'h001);

  // both enables set drives neither side
  assign want_hs = hs_en & ~ls_en & ~hs_block;
  assign want_ls = ls_en & ~hs_en & ~ls_block;

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hs_cnt_q <= 12'h000;
      ls_cnt_q <= 12'h000;
      hs_trip_q <= 1'b0;
      ls_trip_q <= 1'b0;
    end else begin
      hs_cnt_q <= filt_next(hs_cnt_q, hs_act);
      ls_cnt_q <= filt_next(ls_cnt_q, ls_act);
      hs_trip_q <= hs_trip;
      ls_trip_q <= ls_trip;
    end
  end

  // ---------------------------------------------------------------
  // switch sequencing with dead time
  // ---------------------------------------------------------------
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hs_on_q <= 1'b0;
      ls_on_q <= 1'b0;
      dt_q <= 8'h00;
    end else if (hs_on_q && (!want_hs || hs_trip)) begin
      hs_on_q <= 1'b0;
      dt_q <= DT_HL;
    end else if (ls_on_q && (!want_ls || ls_trip)) begin
      ls_on_q <= 1'b0;
      dt_q <= DT_LH;
    end else if (dt_q != 8'h00) begin
      dt_q <= dt_q - 8'h01;
    end else if (want_hs && !ls_on_q) begin
      hs_on_q <= 1'b1;
    end else if (want_ls && !hs_on_q) begin
      ls_on_q <= 1'b1;
    end
  end

endmodule // hbfp_bridge

// ===== hdl/hbfp_top.v
// fault protection top: ahb-lite registers, fault latching, eight half-bridges
`timescale 1ns/10ps
`include "hbfp_map.vh"

module hbfp_top #(
  parameter [11:0] OC_FILT_CYC = `HBFP_OC_FILT_CYC
) (
  // clock and reset
  input wire hclk,
  input wire hresetn,
  // ahb-lite slave
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  input wire hready,
  output reg [31:0] hrdata,
  output wire hreadyout,
  output wire hresp,
  // per-switch detectors
  input wire [7:0] oc_hs_det,
  input wire [7:0] oc_ls_det,
  input wire [7:0] ol_hs_det,
  input wire [7:0] ol_ls_det,
  // analog monitors
  input wire temp_warn_raw,
  input wire temp_sd_raw,
  input wire supply_uv_raw,
  input wire supply_ov_raw,
  // power stage and indicators
  output wire [7:0] hs_gate,
  output wire [7:0] ls_gate,
  output reg fault_indicator_n,
  output reg irq
);

  // ---------------------------------------------------------------
  // declarations
  // ---------------------------------------------------------------
  reg [3:0] mon_meta_q;
  reg [3:0] mon_sync_q;
  reg [6:0] global_status_one_q;
  reg [6:0] irq_mask_q;
  reg [7:0] high_side_overcurrent_flag_q;
  reg [7:0] low_side_overcurrent_flag_q;
  reg [7:0] high_side_openload_flag_q;
  reg [7:0] low_side_openload_flag_q;
  reg [15:0] bridge_activation_control_q;
  reg dph_valid_q;
  reg dph_write_q;
  reg [5:0] dph_addr_q;
  reg [6:0] gstat_d;
  reg [6:0] gstat_set;
  reg [31:0] rd_word_d;
  wire [7:0] high_side_enable;
  wire [7:0] low_side_enable;
  wire [7:0] hs_trip;
  wire [7:0] ls_trip;
  wire [7:0] hs_ol_set;
  wire [7:0] ls_ol_set;
  wire temp_prewarn_live;
  wire temp_sd_live;
  wire supply_uv_live;
  wire supply_ov_live;
  wire outputs_off;
  wire wr_en;
  wire [6:0] gstat_clr;
  wire [15:0] oc_clr;
  wire [15:0] ol_clr;
  wire [15:0] oc_flags;
  wire [15:0] ol_flags;
  wire [15:0] oc_next;
  wire [15:0] ol_next;
  wire any_flag;
  wire [15:0] act_d;
  wire [6:0] mask_d;

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  // sticky flag update, a set in the clearing cycle wins
  function [15:0] sticky_next;
    input [15:0] q;
    input [15:0] set;
    input [15:0] clr;
    begin
      sticky_next = (q & ~clr) | set;
    end
  endfunction

  function is_write;
    input [5:0] a;
    input [5:0] target;
    input en;
    begin
      is_write = en && (a == target);
    end
  endfunction

  // ---------------------------------------------------------------
  // ahb-lite slave, zero wait states
  // ---------------------------------------------------------------
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dph_valid_q <= 1'b0;
      dph_write_q <= 1'b0;
      dph_addr_q <= 6'h00;
    end else if (hready) begin
      dph_valid_q <= hsel & htrans[1];
      dph_write_q <= hwrite;
      dph_addr_q <= haddr[7:2];
    end
  end

  assign wr_en = dph_valid_q & dph_write_q;

  // read word as the register will stand after this edge
  always @* begin
    rd_word_d = 32'h0000_0000;
    case (haddr[7:2])
      `HBFP_A_GSTAT: rd_word_d = {25'h000_0000, gstat_d};
      `HBFP_A_OC: rd_word_d = {16'h0000, oc_next};
      `HBFP_A_OL: rd_word_d = {16'h0000, ol_next};
      `HBFP_A_ACT: rd_word_d = {16'h0000, act_d};
      `HBFP_A_LIVE: rd_word_d = {12'h000, mon_sync_q, ls_gate, hs_gate};
      `HBFP_A_MASK: rd_word_d = {25'h000_0000, mask_d};
      default: rd_word_d = 32'h0000_0000;
    endcase
  end

  // read data loaded as the address phase is taken; a write in flight is seen
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0000_0000;
    end else if (hready) begin
      if (hsel && htrans[1] && !hwrite) begin
        hrdata <= rd_word_d;
      end else begin
        hrdata <= 32'h0000_0000;
      end
    end
  end

  // ---------------------------------------------------------------
  // monitor synchroniser
  // ---------------------------------------------------------------
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      mon_meta_q <= 4'h0;
      mon_sync_q <= 4'h0;
    end else begin
      mon_meta_q <= {supply_ov_raw, supply_uv_raw, temp_sd_raw, temp_warn_raw};
      mon_sync_q <= mon_meta_q;
    end
  end

  assign temp_prewarn_live = mon_sync_q[0];
  assign temp_sd_live = mon_sync_q[1];
  assign supply_uv_live = mon_sync_q[2];
  assign supply_ov_live = mon_sync_q[3];

  // ---------------------------------------------------------------
  // activation control and mask
  // ---------------------------------------------------------------
  assign act_d = is_write(dph_addr_q, `HBFP_A_ACT, wr_en) ? hwdata[15:0] :
                 bridge_activation_control_q;
  assign mask_d = is_write(dph_addr_q, `HBFP_A_MASK, wr_en) ?
                  (hwdata[6:0] & `HBFP_GSTAT_MASK) : irq_mask_q;

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      bridge_activation_control_q <= `HBFP_RST_ACT;
      irq_mask_q <= `HBFP_RST_MASK;
    end else begin
      // fault events never touch the enable bits
      bridge_activation_control_q <= act_d;
      irq_mask_q <= mask_d;
    end
  end

  assign high_side_enable = bridge_activation_control_q[7:0];
  assign low_side_enable = bridge_activation_control_q[15:8];

  // ---------------------------------------------------------------
  // per-switch flags
  // ---------------------------------------------------------------
  assign oc_flags = {low_side_overcurrent_flag_q, high_side_overcurrent_flag_q};
  assign ol_flags = {low_side_openload_flag_q, high_side_openload_flag_q};
  assign oc_clr = is_write(dph_addr_q, `HBFP_A_OC, wr_en) ? hwdata[15:0] : 16'h0000;
  assign ol_clr = is_write(dph_addr_q, `HBFP_A_OL, wr_en) ? hwdata[15:0] : 16'h0000;
  assign hs_ol_set = ol_hs_det & hs_gate;
  assign ls_ol_set = ol_ls_det & ls_gate;
  assign oc_next = sticky_next(oc_flags, {ls_trip, hs_trip}, oc_clr);
  assign ol_next = sticky_next(ol_flags, {ls_ol_set, hs_ol_set}, ol_clr);

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      high_side_overcurrent_flag_q <= 8'h00;
      low_side_overcurrent_flag_q <= 8'h00;
      high_side_openload_flag_q <= 8'h00;
      low_side_openload_flag_q <= 8'h00;
    end else begin
      high_side_overcurrent_flag_q <= oc_next[7:0];
      low_side_overcurrent_flag_q <= oc_next[15:8];
      high_side_openload_flag_q <= ol_next[7:0];
      low_side_openload_flag_q <= ol_next[15:8];
    end
  end

  // ---------------------------------------------------------------
  // global status
  // ---------------------------------------------------------------
  assign gstat_clr = is_write(dph_addr_q, `HBFP_A_GSTAT, wr_en) ?
                     (hwdata[6:0] & `HBFP_GSTAT_MASK) : 7'h00;

  always @* begin
    gstat_set = 7'h00;
    gstat_set[`HBFP_B_PREWARN] = temp_prewarn_live;
    gstat_set[`HBFP_B_TSD] = temp_sd_live;
    gstat_set[`HBFP_B_OV] = supply_ov_live;
    gstat_set[`HBFP_B_UV] = supply_uv_live;
    gstat_set[`HBFP_B_LE] = (|hs_trip) | (|ls_trip) | (|hs_ol_set) | (|ls_ol_set);
    gstat_d = (global_status_one_q & ~gstat_clr) | gstat_set;
  end

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      global_status_one_q <= `HBFP_RST_GSTAT;
    end else begin
      global_status_one_q <= gstat_d;
    end
  end

  // thermal shutdown holds until cleared, supply faults follow the live level
  assign outputs_off = global_status_one_q[`HBFP_B_TSD] |
                       supply_uv_live |
                       supply_ov_live;

  // ---------------------------------------------------------------
  // fault pin and interrupt
  // ---------------------------------------------------------------
  assign any_flag = (|global_status_one_q) | (|oc_flags) | (|ol_flags);

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      fault_indicator_n <= 1'b1;
      irq <= 1'b0;
    end else begin
      fault_indicator_n <= ~any_flag;
      irq <= |(global_status_one_q & irq_mask_q);
    end
  end

  // ---------------------------------------------------------------
  // half-bridges
  // ---------------------------------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi = gi + 1) begin : g_bridge
      hbfp_bridge #(
        .FILT_CYC(OC_FILT_CYC)
      ) u_bridge (
        .hclk(hclk),
        .hresetn(hresetn),
        .hs_en(high_side_enable[gi]),
        .ls_en(low_side_enable[gi]),
        .hs_block(high_side_overcurrent_flag_q[gi] | outputs_off),
        .ls_block(low_side_overcurrent_flag_q[gi] | outputs_off),
        .hs_oc_det(oc_hs_det[gi]),
        .ls_oc_det(oc_ls_det[gi]),
        .hs_on_q(hs_gate[gi]),
        .ls_on_q(ls_gate[gi]),
        .hs_trip_q(hs_trip[gi]),
        .ls_trip_q(ls_trip[gi])
      );
    end
  endgenerate

endmodule // hbfp_top

// ===== bench/hbfp_stage_model.sv
// power stage model: switch current comparators seen by the block
`timescale 1ns/10ps
module hbfp_stage_model (
  // gate drive
  input wire [7:0] hs_gate,
  input wire [7:0] ls_gate,
  // shorted switches, {ls, hs}
  input wire [15:0] short_mask,
  // comparators
  output wire [7:0] oc_hs_det,
  output wire [7:0] oc_ls_det
);
  // a short only draws current through a switch that is on
  assign oc_hs_det = hs_gate & short_mask[7:0];
  assign oc_ls_det = ls_gate & short_mask[15:8];
endmodule // hbfp_stage_model

// ===== bench/hbfp_checker.sv
// assertion checker for the bridge protection top
`timescale 1ns/10ps
module hbfp_checker #(
  parameter [11:0] OC_FILT_CYC = 12'd400
) (
  input wire hclk,
  input wire hresetn,
  input wire hsel,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [7:0] oc_hs_det,
  input wire [7:0] ol_hs_det,
  input wire temp_sd_raw,
  input wire supply_uv_raw,
  input wire supply_ov_raw,
  input wire [7:0] hs_gate,
  input wire [7:0] ls_gate,
  input wire fault_indicator_n
);
  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  localparam int OCW = OC_FILT_CYC + 2;
  wire wr_req = hsel & htrans[1] & hwrite;
  wire all_off = (hs_gate == 8'h00) && (ls_gate == 8'h00);
  reg [7:0] dt_q;
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dt_q <= 8'hff;
    end else if (hs_gate[0] | ls_gate[0]) begin
      dt_q <= 8'h00;
    end else if (dt_q != 8'hff) begin
      dt_q <= dt_q + 8'h01;
    end
  end
  // ---------------------------------------------------------------
  // properties
  // ---------------------------------------------------------------
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  AST_NO_CROSS: assert property ((hs_gate & ls_gate) == 8'h00)
    else $error("both gates of a bridge on");
  AST_DEAD_TIME: assert property ($rose(ls_gate[0]) |-> dt_q >= 8'd38)
    else $error("low gate on inside dead time");
  AST_OC_HOLD: assert property ($rose(oc_hs_det[0]) |-> hs_gate[0] [*3])
    else $error("instant overcurrent shutdown");
  AST_OC_TRIP: assert property ($rose(oc_hs_det[0]) |-> ##[1:OCW] !hs_gate[0])
    else $error("overcurrent never tripped");
  AST_OC_FLAG: assert property ($fell(hs_gate[0]) && $past(oc_hs_det[0]) |->
    ##[1:3] !fault_indicator_n) else $error("fault pin not low after trip");
  AST_FAULT_STICKY: assert property ((!fault_indicator_n && !$past(wr_req, 2))
    |=> !fault_indicator_n) else $error("fault pin released");
  AST_TSD_OFF: assert property (temp_sd_raw [*5] |-> all_off)
    else $error("gates on in thermal shutdown");
  AST_UV_OFF: assert property (supply_uv_raw [*4] |-> all_off)
    else $error("gates on in undervoltage");
  AST_OV_OFF: assert property (supply_ov_raw [*4] |-> all_off)
    else $error("gates on in overvoltage");
  AST_OL_KEEP: assert property (hs_gate[2] && $rose(ol_hs_det[2]) |=> hs_gate[2] [*3])
    else $error("open load changed output");
endmodule // hbfp_checker

// ===== bench/tb_hbfp_top.sv
// testbench for the bridge protection top
`timescale 1ns/10ps
module tb_hbfp_top;
  reg hclk = 1'b0;
  reg hresetn = 1'b0;
  reg hsel = 1'b0;
  reg [31:0] haddr = 32'h0;
  reg [1:0] htrans = 2'h0;
  reg hwrite = 1'b0;
  reg [31:0] hwdata = 32'h0;
  reg [15:0] ol_det = 16'h0;
  reg [15:0] short_mask = 16'h0;
  reg [3:0] mon = 4'h0;
  reg [31:0] rd_q;
  wire [31:0] hrdata;
  wire hreadyout;
  wire hresp;
  wire [7:0] oc_hs_det;
  wire [7:0] oc_ls_det;
  wire [7:0] hs_gate;
  wire [7:0] ls_gate;
  wire fault_indicator_n;
  wire irq;
  wire [15:0] gates = {ls_gate, hs_gate};
  integer bad_count = 0;
  integer compares = 0;
  integer cyc = 0;
  always #12.5 hclk = ~hclk;
  always @(posedge hclk) rd_q <= hrdata;
  hbfp_top #(.OC_FILT_CYC(12'd4)) u_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
    .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .oc_hs_det(oc_hs_det), .oc_ls_det(oc_ls_det), .ol_hs_det(ol_det[7:0]),
    .ol_ls_det(ol_det[15:8]), .temp_warn_raw(mon[0]), .temp_sd_raw(mon[1]),
    .supply_uv_raw(mon[2]), .supply_ov_raw(mon[3]), .hs_gate(hs_gate), .ls_gate(ls_gate),
    .fault_indicator_n(fault_indicator_n), .irq(irq));
  hbfp_stage_model u_stage (.hs_gate(hs_gate), .ls_gate(ls_gate), .short_mask(short_mask),
    .oc_hs_det(oc_hs_det), .oc_ls_det(oc_ls_det));
  // ---------------------------------------------------------------
  // bus and check tasks
  // ---------------------------------------------------------------
  task check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    compares = compares + 1;
    if (seen !== exp) begin
      bad_count = bad_count + 1;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask
  task ahb(input logic wr, input logic [31:0] a, input logic [31:0] d, output logic [31:0] q);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'h2;
    hwrite <= wr;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    #1;
    q = rd_q;
  endtask
  task wr(input logic [31:0] a, input logic [31:0] d);
    logic [31:0] q;
    ahb(1'b1, a, d, q);
  endtask
  task rd_chk(input logic [31:0] a, input logic [31:0] exp, input string what);
    logic [31:0] q;
    ahb(1'b0, a, 32'h0, q);
    check(q, exp, what);
  endtask
  task wait_cyc(input integer n);
    repeat (n) @(posedge hclk);
    #1;
  endtask
  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task t_reset;
    integer i;
    check(fault_indicator_n, 32'h1, "fault pin idle");
    check(irq, 32'h0, "irq idle");
    check(hresp, 32'h0, "okay response");
    for (i = 0; i < 7; i = i + 1) rd_chk(i * 4, 32'h0, "reset value");
    $display("test reset done");
  endtask
  task t_oc(input integer k);
    @(posedge hclk);
    short_mask <= 16'h1 << k;
    wr(32'h0c, 32'h1 << k);
    wait_cyc(60);
    check(gates, 32'h0, "gates after trip");
    rd_chk(32'h04, 32'h1 << k, "overcurrent flags");
    rd_chk(32'h00, 32'h40, "load error");
    rd_chk(32'h0c, 32'h1 << k, "enables kept");
    check(fault_indicator_n, 32'h0, "fault pin");
    @(posedge hclk);
    short_mask <= 16'h0;
    wr(32'h04, 32'h1 << k);
    wait_cyc(50);
    check(gates, 32'h1 << k, "gate back");
    wr(32'h00, 32'h40);
    wr(32'h0c, 32'h0);
    wait_cyc(4);
    check(fault_indicator_n, 32'h1, "fault pin cleared");
    $display("test overcurrent %0d done", k);
  endtask
  task t_dead;
    wr(32'h0c, 32'h0001);
    wait_cyc(50);
    check(hs_gate[0], 32'h1, "high gate on");
    wr(32'h0c, 32'h0100);
    wait_cyc(30);
    check(ls_gate[0], 32'h0, "low gate in dead time");
    wait_cyc(15);
    check(ls_gate[0], 32'h1, "low gate after dead time");
    wr(32'h0c, 32'h0101);
    wait_cyc(50);
    check(gates, 32'h0, "both enables set");
    wr(32'h0c, 32'h0);
    $display("test dead time done");
  endtask
  task t_ol;
    wr(32'h0c, 32'h0004);
    wait_cyc(50);
    wr(32'h14, 32'h40);
    @(posedge hclk);
    ol_det <= 16'h0004;
    wait_cyc(4);
    check(hs_gate[2], 32'h1, "gate with open load");
    check(irq, 32'h1, "irq raised");
    rd_chk(32'h08, 32'h4, "open load flags");
    rd_chk(32'h00, 32'h40, "load error");
    wr(32'h14, 32'h0);
    wait_cyc(3);
    check(irq, 32'h0, "irq masked");
    @(posedge hclk);
    ol_det <= 16'h0;
    wr(32'h14, 32'h40);
    wr(32'h08, 32'h4);
    wr(32'h00, 32'h40);
    wait_cyc(3);
    check(irq, 32'h0, "irq cleared");
    wr(32'h0c, 32'h0);
    $display("test open load done");
  endtask
  task t_mon;
    integer i;
    logic [31:0] b;
    for (i = 0; i < 4; i = i + 1) begin
      b = (i == 0) ? 32'h02 : (i == 1) ? 32'h04 : (i == 2) ? 32'h20 : 32'h10;
      wr(32'h0c, 32'h0001);
      wait_cyc(50);
      @(posedge hclk);
      mon <= 4'h1 << i;
      wait_cyc(8);
      check(hs_gate[0], i == 0, "gate in fault");
      check(fault_indicator_n, 32'h0, "fault pin");
      @(posedge hclk);
      mon <= 4'h0;
      wait_cyc(50);
      check(hs_gate[0], i != 1, "gate after recovery");
      rd_chk(32'h00, b, "monitor flag");
      wr(32'h00, b);
      wait_cyc(50);
      check(hs_gate[0], 32'h1, "gate after clear");
      wr(32'h0c, 32'h0);
    end
    $display("test monitors done");
  endtask
  // ---------------------------------------------------------------
  // sequence, timeout and verdict
  // ---------------------------------------------------------------
  task end_sim;
    $display("comparisons %0d mismatches %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  initial begin
    repeat (6) @(posedge hclk);
    hresetn <= 1'b1;
    wait_cyc(2);
    t_reset;
    t_oc(0);
    t_oc(9);
    t_dead;
    t_ol;
    t_mon;
    end_sim;
  end
  always @(posedge hclk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      bad_count = bad_count + 1;
      $display("unexpected run length: expected under 5000 seen %0d", cyc);
      end_sim;
    end
  end
endmodule // tb_hbfp_top
bind hbfp_top hbfp_checker #(.OC_FILT_CYC(OC_FILT_CYC)) u_chk (.hclk(hclk), .hresetn(hresetn),
  .hsel(hsel), .htrans(htrans), .hwrite(hwrite), .oc_hs_det(oc_hs_det), .ol_hs_det(ol_hs_det),
  .temp_sd_raw(temp_sd_raw), .supply_uv_raw(supply_uv_raw), .supply_ov_raw(supply_ov_raw),
  .hs_gate(hs_gate), .ls_gate(ls_gate), .fault_indicator_n(fault_indicator_n));
